// *** hdl/xlate_pkg.sv ***
// constants shared by the address front end and its translator
// assumes a single 100 MHz core clock domain
package xlate_pkg;
  localparam int LBA_W = 28;
  localparam int CYL_W = 16;
  localparam int HEAD_W = 4;
  localparam int SECT_W = 8;
  localparam int CNT_W = 8;
  localparam int ECC_W = 5;
  localparam logic [HEAD_W:0] DEF_HEADS = 5'h10;
  localparam logic [SECT_W-1:0] DEF_SPT = 8'h3f;
  localparam logic [CYL_W-1:0] DEF_CYLS = 16'h4000;
  localparam logic [LBA_W-1:0] DEF_CAPACITY = 28'h0fc0000;
  localparam logic [LBA_W-1:0] RPT_SMALL = 28'h03ffc10;
  localparam logic [LBA_W-1:0] RPT_LARGE = 28'h3d09000;
  localparam logic [LBA_W-1:0] LIMIT_BOUND = 28'h3d09000;
  localparam logic [ECC_W-1:0] ECC_HW_MAX = 5'h05;
  localparam logic [ECC_W-1:0] ECC_SW_MAX = 5'h16;
  localparam logic [SECT_W-1:0] ONE_SECT = 8'h01;
  localparam logic [CNT_W-1:0] ONE_CNT = 8'h01;
  localparam int MUL_CYCLES = 3;
  typedef enum logic [2:0] {ST_IDLE, ST_CALC, ST_CHECK, ST_XFER, ST_DONE} cmd_st_t;
endpackage

// *** hdl/lba_calc.sv ***
// converts host cylinder/head/sector to a logical block address
// assumes operands stay stable from start until done is pulsed
module lba_calc
  import xlate_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [SECT_W-1:0] sect_i,
  input wire logic [HEAD_W-1:0] head_i,
  input wire logic [CYL_W-1:0] cyl_i,
  input wire logic [HEAD_W:0] nheads_i,
  input wire logic [SECT_W-1:0] spt_i,
  output logic done_o,
  output logic [LBA_W-1:0] lba_o
);
  typedef struct packed {
    logic [1:0] step;
    logic busy;
    logic done;
    logic [LBA_W-1:0] acc;
  } calc_t;
  calc_t s_reg, s_next;
  logic [LBA_W+7:0] tmp;
  always_comb begin
    s_next = s_reg;
    tmp = '0;
    s_next.done = 1'b0;
    if (start_i) begin
      s_next.busy = 1'b1;
      s_next.step = 2'h0;
    end else if (s_reg.busy) begin
      unique case (s_reg.step)
        2'h0: begin
          tmp = (LBA_W+8)'(nheads_i) * (LBA_W+8)'(cyl_i);
          s_next.acc = tmp[LBA_W-1:0];
          s_next.step = 2'h1;
        end
        2'h1: begin
          tmp = (LBA_W+8)'(spt_i) * (LBA_W+8)'(s_reg.acc + LBA_W'(head_i));
          s_next.acc = tmp[LBA_W-1:0];
          s_next.step = 2'h2;
        end
        default: begin
          s_next.acc = s_reg.acc + LBA_W'(sect_i - ONE_SECT);
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
        end
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign done_o = s_reg.done;
  assign lba_o = s_reg.acc;
endmodule

// *** hdl/host_xlate_select.sv ***
// task file front end: drive selection, address translation and cache policy
// assumes task file strobes and straps come from the host pins, asynchronous
// Operation
// - lba equals sector minus one plus spt times (head plus heads times cylinder).
// - each lba is checked against capacity before any physical access.
// - power-up geometry is 16 heads, 63 sectors, model cylinder count.
// - any host geometry whose total fits capacity is accepted.
// - landing zone and write precomp values are ignored.
// - two drives share addresses; drive select bit picks the target.
// - both drives capture every task file write.
// - only the selected drive executes and drives read data.
// - closed master jumper means device 0, open means device 1.
// - cable select grounded gives address 0, open gives 1.
// - cylinder limit jumper reports 2.1GB up to 32GB, else 32GB.
// - reassigned sector pushes it and all following down one.
// - read-ahead fills buffer and checks new reads against it.
// - cache hit starts host transfer without stopping read-ahead.
// - cached writes fill buffer, then command-complete interrupt.
// - cached writes accepted until stack or buffer full.
// - deferred write error halts, remaps to spare, resumes.
// - multiple mode moves the block count with no per-sector interrupt.
// - hardware fixes bursts up to 5 symbols, software up to 22.
module host_xlate_select
  import xlate_pkg::*;
(
  input wire logic CORE_CLK_I, // core clock
  input wire logic SYS_RST_I, // sync reset
  input wire logic TF_WR_I, // task file write strobe (pin)
  input wire logic [2:0] TF_ADDR_I, // task file register index
  input wire logic [7:0] TF_DATA_I, // task file write data
  input wire logic HOST_RD_I, // host data read strobe (pin)
  input wire logic MASTER_JUMPER_N_I, // low when jumper closed
  input wire logic CSEL_EN_I, // cable select in use
  input wire logic CSEL_I, // cable select line level
  input wire logic CYLINDER_LIMIT_JUMPER_N_I, // low when closed
  input wire logic [LBA_W-1:0] CAPACITY_I, // formatted capacity in sectors
  input wire logic [LBA_W-1:0] DEFECT_LBA_I, // reassigned sector, push-down start
  input wire logic DEFECT_VALID_I, // a reassigned sector exists
  input wire logic READ_AHEAD_EN_I, // read-ahead enable
  input wire logic WRITE_CACHE_EN_I, // write cache enable
  input wire logic BUF_FULL_I, // data buffer full
  input wire logic STACK_FULL_I, // write command stack full
  input wire logic DISK_WR_ERR_I, // deferred write disk error
  input wire logic [ECC_W-1:0] ECC_BURST_I, // detected burst length
  input wire logic ECC_EVENT_I, // burst detected
  output logic SELECTED_O, // this drive is selected
  output logic DATA_OE_O, // data bus output enable
  output logic CMD_ERR_O, // command ended with error
  output logic CMD_DONE_O, // command complete interrupt pulse
  output logic MEDIA_GO_O, // start media access
  output logic [LBA_W-1:0] PHYS_LBA_O, // pushed-down physical block
  output logic XFER_START_O, // start host transfer
  output logic READ_AHEAD_O, // read-ahead running
  output logic REMAP_O, // remap failing sector pulse
  output logic [LBA_W-1:0] REPORT_CAP_O, // capacity for identify data
  output logic [HEAD_W:0] HEADS_O, // current geometry heads
  output logic [SECT_W-1:0] SPT_O, // current geometry sectors per track
  output logic ECC_HW_O, // burst fixed on the fly
  output logic ECC_SW_O // burst needs software correction
);
  localparam logic [2:0] TA_CNT = 3'h2;
  localparam logic [2:0] TA_SECT = 3'h3;
  localparam logic [2:0] TA_CYLL = 3'h4;
  localparam logic [2:0] TA_CYLH = 3'h5;
  localparam logic [2:0] TA_DEVHEAD = 3'h6;
  localparam logic [2:0] TA_CMD = 3'h7;
  localparam int DEV_BIT = 4;
  localparam logic [7:0] CMD_READ = 8'h20;
  localparam logic [7:0] CMD_WRITE = 8'h30;
  localparam logic [7:0] CMD_RD_MULT = 8'hc4;
  localparam logic [7:0] CMD_WR_MULT = 8'hc5;
  localparam logic [7:0] CMD_INIT_GEOM = 8'h91;

  typedef struct packed {
    logic [2:0] wr_sync;
    logic [2:0] rd_sync;
    logic [1:0] mj_sync;
    logic [1:0] cs_sync;
    logic [1:0] cl_sync;
    logic [1:0] ce_sync;
    logic [2:0] addr_s1;
    logic [2:0] addr_s2;
    logic [7:0] data_s1;
    logic [7:0] data_s2;
    logic dev_id;
    logic dev_sel;
    logic [SECT_W-1:0] sect;
    logic [SECT_W-1:0] cnt;
    logic [CYL_W-1:0] cyl;
    logic [HEAD_W-1:0] head;
    logic [HEAD_W:0] nheads;
    logic [SECT_W-1:0] spt;
    logic [7:0] cmd;
    cmd_st_t st;
    logic calc_go;
    logic [LBA_W-1:0] lba;
    logic [CNT_W-1:0] left;
    logic ra_on;
    logic [LBA_W-1:0] ra_lo;
    logic [LBA_W-1:0] ra_hi;
    logic halted;
    logic selected;
    logic data_oe;
    logic err;
    logic done;
    logic media_go;
    logic [LBA_W-1:0] phys;
    logic xfer;
    logic remap;
    logic [LBA_W-1:0] rep_cap;
    logic ecc_hw;
    logic ecc_sw;
  } fe_t;
  fe_t s_reg, s_next;
  logic calc_done;
  logic [LBA_W-1:0] calc_lba;
  logic wr_pulse, rd_level, is_write, is_mult;

  lba_calc u_calc (
    .clk_i(CORE_CLK_I),
    .rst_i(SYS_RST_I),
    .start_i(s_reg.calc_go),
    .sect_i(s_reg.sect),
    .head_i(s_reg.head),
    .cyl_i(s_reg.cyl),
    .nheads_i(s_reg.nheads),
    .spt_i(s_reg.spt),
    .done_o(calc_done),
    .lba_o(calc_lba)
  );

  always_comb begin
    s_next = s_reg;
    s_next.wr_sync = {s_reg.wr_sync[1:0], TF_WR_I};
    s_next.rd_sync = {s_reg.rd_sync[1:0], HOST_RD_I};
    s_next.mj_sync = {s_reg.mj_sync[0], MASTER_JUMPER_N_I};
    s_next.cs_sync = {s_reg.cs_sync[0], CSEL_I};
    s_next.cl_sync = {s_reg.cl_sync[0], CYLINDER_LIMIT_JUMPER_N_I};
    s_next.ce_sync = {s_reg.ce_sync[0], CSEL_EN_I};
    // address and data are pins too; held stable around the strobe
    s_next.addr_s1 = TF_ADDR_I;
    s_next.addr_s2 = s_reg.addr_s1;
    s_next.data_s1 = TF_DATA_I;
    s_next.data_s2 = s_reg.data_s1;
    wr_pulse = s_reg.wr_sync[1] & ~s_reg.wr_sync[2];
    rd_level = s_reg.rd_sync[1];
    is_write = (s_reg.cmd == CMD_WRITE) || (s_reg.cmd == CMD_WR_MULT);
    is_mult = (s_reg.cmd == CMD_RD_MULT) || (s_reg.cmd == CMD_WR_MULT);
    s_next.calc_go = 1'b0;
    s_next.done = 1'b0;
    s_next.media_go = 1'b0;
    s_next.xfer = 1'b0;
    s_next.remap = 1'b0;
    s_next.dev_id = s_reg.ce_sync[1] ? s_reg.cs_sync[1] : s_reg.mj_sync[1];
    s_next.selected = (s_reg.dev_sel == s_reg.dev_id);
    s_next.data_oe = s_next.selected & rd_level;
    s_next.rep_cap = CAPACITY_I;
    if (!s_reg.cl_sync[1]) begin
      s_next.rep_cap = (CAPACITY_I <= LIMIT_BOUND) ? RPT_SMALL : RPT_LARGE;
    end
    s_next.ecc_hw = ECC_EVENT_I && (ECC_BURST_I <= ECC_HW_MAX);
    s_next.ecc_sw = ECC_EVENT_I && (ECC_BURST_I > ECC_HW_MAX) && (ECC_BURST_I <= ECC_SW_MAX);
    // every write lands here whatever the selection; precomp/zone unused
    if (wr_pulse) begin
      unique case (s_reg.addr_s2)
        TA_CNT: s_next.cnt = s_reg.data_s2;
        TA_SECT: s_next.sect = s_reg.data_s2;
        TA_CYLL: s_next.cyl[7:0] = s_reg.data_s2;
        TA_CYLH: s_next.cyl[15:8] = s_reg.data_s2;
        TA_DEVHEAD: begin
          s_next.dev_sel = s_reg.data_s2[DEV_BIT];
          s_next.head = s_reg.data_s2[HEAD_W-1:0];
        end
        TA_CMD: s_next.cmd = s_reg.data_s2;
        default: s_next.cmd = s_reg.cmd;
      endcase
    end
    unique case (s_reg.st)
      ST_IDLE: begin
        if (wr_pulse && s_reg.addr_s2 == TA_CMD && s_reg.selected) begin
          if (s_reg.data_s2 == CMD_INIT_GEOM) begin
            s_next.nheads = {1'b0, s_reg.head} + 5'h01;
            s_next.spt = s_reg.cnt;
            s_next.done = 1'b1;
          end else if (!(s_reg.data_s2 inside {CMD_WRITE, CMD_WR_MULT}) || !STACK_FULL_I) begin
            s_next.calc_go = 1'b1;
            s_next.st = ST_CALC;
          end
        end
      end
      ST_CALC: begin
        if (calc_done) begin
          s_next.lba = calc_lba;
          s_next.st = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (s_reg.lba >= CAPACITY_I) begin
          s_next.err = 1'b1;
          s_next.done = 1'b1;
          s_next.st = ST_IDLE;
        end else begin
          s_next.err = 1'b0;
          s_next.phys = s_reg.lba;
          if (DEFECT_VALID_I && s_reg.lba >= DEFECT_LBA_I) begin
            s_next.phys = s_reg.lba + LBA_W'(1);
          end
          s_next.left = (s_reg.cnt == '0) ? ONE_CNT : s_reg.cnt;
          if (!is_write && s_reg.ra_on && s_reg.lba >= s_reg.ra_lo
              && s_reg.lba < s_reg.ra_hi) begin
            s_next.xfer = 1'b1;
          end else begin
            s_next.media_go = 1'b1;
            s_next.xfer = 1'b1;
            if (!is_write && READ_AHEAD_EN_I) begin
              s_next.ra_on = 1'b1;
              s_next.ra_lo = s_reg.lba;
              s_next.ra_hi = s_reg.lba;
            end
          end
          s_next.st = ST_XFER;
        end
      end
      ST_XFER: begin
        if (rd_level || (is_write && WRITE_CACHE_EN_I && !BUF_FULL_I)) begin
          s_next.left = s_reg.left - ONE_CNT;
          if (!is_mult || s_reg.left == ONE_CNT) begin
            s_next.done = 1'b1;
          end
          if (s_reg.left == ONE_CNT) begin
            s_next.st = ST_IDLE;
          end
        end else if (is_write && WRITE_CACHE_EN_I && BUF_FULL_I) begin
          s_next.done = 1'b1;
          s_next.st = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!BUF_FULL_I) begin
          s_next.st = ST_IDLE;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
    if (s_reg.ra_on) begin
      if (!READ_AHEAD_EN_I) begin
        s_next.ra_on = 1'b0;
      end else if (!BUF_FULL_I) begin
        s_next.ra_hi = s_reg.ra_hi + LBA_W'(1);
      end
    end
    if (DISK_WR_ERR_I && !s_reg.halted) begin
      s_next.halted = 1'b1;
      s_next.remap = 1'b1;
    end else if (s_reg.halted) begin
      s_next.halted = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      s_reg <= '0;
      // open jumper level, so no false limit right after reset
      s_reg.cl_sync <= '1;
      s_reg.nheads <= DEF_HEADS;
      s_reg.spt <= DEF_SPT;
      s_reg.cyl <= DEF_CYLS;
      s_reg.st <= ST_IDLE;
      s_reg.rep_cap <= DEF_CAPACITY;
    end else begin
      s_reg <= s_next;
    end
  end

  assign SELECTED_O = s_reg.selected;
  assign DATA_OE_O = s_reg.data_oe;
  assign CMD_ERR_O = s_reg.err;
  assign CMD_DONE_O = s_reg.done;
  assign MEDIA_GO_O = s_reg.media_go;
  assign PHYS_LBA_O = s_reg.phys;
  assign XFER_START_O = s_reg.xfer;
  assign READ_AHEAD_O = s_reg.ra_on;
  assign REMAP_O = s_reg.remap;
  assign REPORT_CAP_O = s_reg.rep_cap;
  assign HEADS_O = s_reg.nheads;
  assign SPT_O = s_reg.spt;
  assign ECC_HW_O = s_reg.ecc_hw;
  assign ECC_SW_O = s_reg.ecc_sw;

  a_oe_only_selected: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    DATA_OE_O |-> SELECTED_O) else $error("data driven while unselected");
  a_range_err: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (s_reg.st == ST_CHECK && s_reg.lba >= CAPACITY_I) |=> (CMD_ERR_O && !MEDIA_GO_O))
    else $error("out of range not refused");
  a_media_in_range: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    MEDIA_GO_O |-> $past(s_reg.lba) < CAPACITY_I) else $error("media outside range");
  a_push_down: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    MEDIA_GO_O |-> PHYS_LBA_O >= $past(s_reg.lba)) else $error("push-down wrong");
  a_remap_once: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    REMAP_O |=> !REMAP_O) else $error("remap not single pulse");
  a_ecc_hw_limit: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    ECC_HW_O |-> $past(ECC_BURST_I) <= ECC_HW_MAX) else $error("ecc hw limit");
  a_limit_report: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    !$past(s_reg.cl_sync[1])
    |-> REPORT_CAP_O == (($past(CAPACITY_I) <= LIMIT_BOUND) ? RPT_SMALL : RPT_LARGE))
    else $error("limit report wrong");
  a_calc_to_check: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    s_reg.calc_go |-> ##[1:5] s_reg.st == ST_CHECK) else $error("lba calc stalled");
  c_err_cmd: cover property (@(posedge CORE_CLK_I) CMD_ERR_O && CMD_DONE_O);
  c_hit: cover property (@(posedge CORE_CLK_I) XFER_START_O && !MEDIA_GO_O);
  c_remap: cover property (@(posedge CORE_CLK_I) REMAP_O);
endmodule

// *** test/host_adapter_model.sv ***
// host adapter model: task file writes and host read strobes
// assumes the drive samples both strobes through its own synchronisers
module host_adapter_model (
  input wire logic clk_i, // core clock
  output logic tf_wr_o, // write strobe
  output logic [2:0] tf_addr_o, // register index
  output logic [7:0] tf_data_o, // write data
  output logic host_rd_o // read strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    tf_wr_o = 1'b0;
    tf_addr_o = 3'h0;
    tf_data_o = 8'h00;
    host_rd_o = 1'b0;
  end
  // both drives see every write; bit 4 of dev/head picks the target
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    tf_addr_o = a;
    tf_data_o = d;
    @(posedge clk_i);
    #1;
    tf_wr_o = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    tf_wr_o = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    // released bus shows no stale value
    tf_data_o = ~d;
  endtask
  task automatic rd();
    @(posedge clk_i);
    #1;
    host_rd_o = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    host_rd_o = 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
endmodule

// *** test/host_xlate_select_tb_top.sv ***
// self-checking bench for the task file front end
// assumes the host adapter model drives all task file traffic
module host_xlate_select_tb_top
  import xlate_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, wr, rd, mj_n, csel_en, csel, cl_n, dval;
  logic ra_en, wc_en, bfull, sfull, werr, ev;
  logic [2:0] addr;
  logic [7:0] data;
  logic [LBA_W-1:0] cap, dlba, plba, rcap, go_lba;
  logic [ECC_W-1:0] burst;
  logic sel, oe, cerr, cdone, go, xs, ehw, esw, rahd, rmp;
  logic [HEAD_W:0] heads;
  logic [SECT_W-1:0] spt;
  int err_total, samples_checked;
  int go_n, done_n, oe_n, xs_n, go_m, done_m, oe_m, xs_m;
  logic [4:0] strap_tab [6] = '{5'h01, 5'h07, 5'h04, 5'h09, 5'h1b, 5'h12};
  logic [6:0] ecc_tab [4] = '{7'h16, 7'h19, 7'h59, 7'h5c};

  host_adapter_model host_u (.clk_i(clk), .tf_wr_o(wr), .tf_addr_o(addr),
    .tf_data_o(data), .host_rd_o(rd));
  host_xlate_select dut_u (.CORE_CLK_I(clk), .SYS_RST_I(rst), .TF_WR_I(wr),
    .TF_ADDR_I(addr), .TF_DATA_I(data), .HOST_RD_I(rd), .MASTER_JUMPER_N_I(mj_n),
    .CSEL_EN_I(csel_en), .CSEL_I(csel), .CYLINDER_LIMIT_JUMPER_N_I(cl_n),
    .CAPACITY_I(cap), .DEFECT_LBA_I(dlba), .DEFECT_VALID_I(dval),
    .READ_AHEAD_EN_I(ra_en), .WRITE_CACHE_EN_I(wc_en), .BUF_FULL_I(bfull),
    .STACK_FULL_I(sfull), .DISK_WR_ERR_I(werr), .ECC_BURST_I(burst),
    .ECC_EVENT_I(ev), .SELECTED_O(sel), .DATA_OE_O(oe), .CMD_ERR_O(cerr),
    .CMD_DONE_O(cdone), .MEDIA_GO_O(go), .PHYS_LBA_O(plba), .XFER_START_O(xs),
    .READ_AHEAD_O(rahd), .REMAP_O(rmp), .REPORT_CAP_O(rcap), .HEADS_O(heads),
    .SPT_O(spt), .ECC_HW_O(ehw), .ECC_SW_O(esw));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // event counters; tests compare differences across a command
  always @(posedge clk) begin
    if (go === 1'b1) begin
      go_n++;
      go_lba = plba;
    end
    if (cdone === 1'b1) begin
      done_n++;
    end
    if (oe === 1'b1) begin
      oe_n++;
    end
    if (xs === 1'b1) begin
      xs_n++;
    end
  end

  task automatic chk(input logic [LBA_W-1:0] got, input logic [LBA_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    go_m = go_n;
    done_m = done_n;
    oe_m = oe_n;
    xs_m = xs_n;
    host_u.wr(3'h7, c);
    repeat (25) @(posedge clk);
    #1;
  endtask
  task automatic final_report();
    $display("err_total=%0d samples_checked=%0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    {rst, mj_n, csel_en, csel, cl_n, dval, ra_en, wc_en} = 8'h89;
    {bfull, sfull, werr, ev} = 4'h0;
    {cap, dlba, burst} = {DEF_CAPACITY, 28'h0000000, 5'h00};
    err_total = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    #1;
    chk(heads, DEF_HEADS);
    chk(spt, DEF_SPT);
    rst = 1'b0;
    foreach (strap_tab[i]) begin
      {csel_en, csel, mj_n} = strap_tab[i][4:2];
      host_u.wr(3'h6, {3'h0, strap_tab[i][1], 4'h3});
      repeat (4) @(posedge clk);
      #1;
      chk(sel, strap_tab[i][0]);
    end
    {csel_en, csel, mj_n} = 3'h0;
    host_u.wr(3'h2, 8'h20);
    host_u.wr(3'h6, 8'h07);
    cmd(8'h91);
    chk(LBA_W'(done_n - done_m), 28'h1);
    chk(heads, 5'h08);
    chk(spt, 8'h20);
    host_u.wr(3'h2, 8'h01);
    host_u.wr(3'h3, 8'h05);
    host_u.wr(3'h4, 8'h02);
    host_u.wr(3'h5, 8'h01);
    host_u.wr(3'h6, 8'h03);
    for (int i = 0; i < 3; i++) begin
      dval = (i != 0);
      dlba = (i == 1) ? 28'h0010264 : 28'h0010265;
      cmd(8'h20);
      chk(LBA_W'(go_n - go_m), 28'h1);
      chk(go_lba, (i == 1) ? 28'h0010265 : 28'h0010264);
      host_u.rd();
      chk(LBA_W'(oe_n - oe_m), 28'h4);
      chk(LBA_W'(done_n - done_m), 28'h1);
    end
    dval = 1'b0;
    cap = 28'h0010264;
    cmd(8'h20);
    chk(LBA_W'(go_n - go_m), 28'h0);
    chk(cerr, 1'b1);
    chk(LBA_W'(done_n - done_m), 28'h1);
    cap = DEF_CAPACITY;
    host_u.wr(3'h6, 8'h13);
    chk(sel, 1'b0);
    cmd(8'h20);
    chk(LBA_W'(go_n - go_m), 28'h0);
    host_u.rd();
    chk(LBA_W'(oe_n - oe_m), 28'h0);
    host_u.wr(3'h3, 8'h06);
    host_u.wr(3'h1, 8'h5a);
    host_u.wr(3'h6, 8'h03);
    ra_en = 1'b1;
    cmd(8'h20);
    chk(go_lba, 28'h0010265);
    chk(cerr, 1'b0);
    host_u.rd();
    chk(rahd, 1'b1);
    host_u.wr(3'h3, 8'h07);
    cmd(8'h20);
    chk(LBA_W'(go_n - go_m), 28'h0);
    chk(LBA_W'(xs_n - xs_m), 28'h1);
    host_u.rd();
    chk(rahd, 1'b1);
    chk(LBA_W'(done_n - done_m), 28'h1);
    ra_en = 1'b0;
    host_u.wr(3'h2, 8'h04);
    cmd(8'hc4);
    host_u.rd();
    chk(LBA_W'(done_n - done_m), 28'h1);
    cmd(8'h20);
    host_u.rd();
    chk(LBA_W'(done_n - done_m), 28'h4);
    host_u.wr(3'h2, 8'h01);
    {wc_en, sfull} = 2'h3;
    cmd(8'h30);
    chk(LBA_W'(go_n - go_m), 28'h0);
    sfull = 1'b0;
    cmd(8'h30);
    chk(LBA_W'(go_n - go_m), 28'h1);
    chk(LBA_W'(done_n - done_m), 28'h1);
    bfull = 1'b1;
    cmd(8'h30);
    chk(LBA_W'(done_n - done_m), 28'h1);
    bfull = 1'b0;
    werr = 1'b1;
    @(posedge clk);
    #1;
    chk(rmp, 1'b1);
    werr = 1'b0;
    @(posedge clk);
    #1;
    chk(rmp, 1'b0);
    cl_n = 1'b0;
    for (int i = 0; i < 3; i++) begin
      cap = LIMIT_BOUND + 28'(i);
      cl_n = (i == 2);
      repeat (8) @(posedge clk);
      #1;
      chk(rcap, (i == 0) ? RPT_SMALL : (i == 1) ? RPT_LARGE : cap);
    end
    foreach (ecc_tab[i]) begin
      burst = ecc_tab[i][6:2];
      ev = 1'b1;
      @(posedge clk);
      #1;
      chk({ehw, esw}, ecc_tab[i][1:0]);
      ev = 1'b0;
      @(posedge clk);
      #1;
    end
    final_report();
  end
endmodule
